/* xpc_exp_model.sv */
// Behavioural model of the external I/O expander on the multiplexed port
`default_nettype none
module xpc_exp_model
    import xpc_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       select_n,
    input  wire logic       sync_clk,
    input  wire logic       rw,
    input  wire logic [3:0] port_out,
    output var  logic [3:0] port_in
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] mem [16];
    logic [3:0] addr_q;

    // Start with a known pattern so the idle port keeps toggling
    initial begin
        port_in = 4'h_5;
    end

    // Address in the high phase, data in the low phase; outside a read data phase port_in just toggles
    always @(posedge clock) begin
        if (!select_n && sync_clk) begin
            addr_q <= port_out;
        end
        if (!select_n && !sync_clk && !rw) begin
            mem[addr_q] <= port_out;
        end
        if (!select_n && !sync_clk && rw) begin
            port_in <= mem[addr_q];
        end else begin
            port_in <= ~port_in;
        end
    end
endmodule : xpc_exp_model
`default_nettype wire

/* xpc_pkg.sv */
// Package for the expander port and clock control block
`default_nettype none
package xpc_pkg;
    // Expander window on the low address byte
    localparam logic [7:0] XPC_EXP_LO        = 8'h_d0;
    localparam logic [7:0] XPC_EXP_HI        = 8'h_df;
    // Sync clock divider: half period minus one, in oscillator clocks
    localparam logic [2:0] XPC_DIV_NORM_HALF = 3'h_1; // Half period minus one, divide by 4
    localparam logic [2:0] XPC_DIV_EXP_HALF  = 3'h_3; // Half period minus one, divide by 8
    // Reset output release delay, clock cycles
    localparam logic [3:0] XPC_RST_DELAY     = 4'h_8;
    // Interrupt control register flag positions
    localparam int         XPC_INT_BIT       = 1;
    localparam int         XPC_TMRX_PIN_BIT  = 7;
    localparam logic [7:0] XPC_ICR_RESET     = 8'h_00;
    // Timer X load values on stop and reset
    localparam logic [7:0] XPC_PRE_X_STOP    = 8'h_ff;
    localparam logic [7:0] XPC_TMR_X_STOP    = 8'h_01;
    localparam logic [3:0] XPC_DIV16_LAST    = 4'h_f;

    typedef enum logic [1:0] {
        XPC_TIMER_MODE, XPC_PULSE_OUT, XPC_EVENT_CNT, XPC_PULSE_WIDTH
    } xpc_tmode_e;

    // Bus request from the core toward the expander
    typedef struct packed {
        logic [7:0] addr;
        logic       write;
        logic [3:0] wdata;
    } xpc_req_s;
endpackage : xpc_pkg
`default_nettype wire

/* xpc_sync.sv */
// Three-stage pin synchroniser with agreement filter
`default_nettype none
module xpc_sync
    import xpc_pkg::*;
(
    input  wire logic clock,
    input  wire logic rstn,
    input  wire logic ce,
    input  wire logic pin,
    output var  logic level
);
    logic s1;
    logic s2;
    logic s3;

    // Shift the pin in; s1 feeds only s2
    always_ff @(posedge clock) begin
        if (!rstn) begin
            s1 <= 1'b1;
            s2 <= 1'b1;
            s3 <= 1'b1;
        end else if (ce) begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // Accept a change only once the later stages agree
    always_ff @(posedge clock) begin
        if (!rstn) begin
            level <= 1'b1;
        end else if (ce && (s2 == s3)) begin
            level <= s3;
        end
    end
endmodule : xpc_sync
`default_nettype wire

/* xpc_timer_x.sv */
// Timer X with prescaler and stop-mode forced source
`default_nettype none
module xpc_timer_x
    import xpc_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rstn,
    input  wire logic       ce,
    input  wire logic       osc_run,
    input  wire logic       stop_load,
    input  wire xpc_tmode_e mode,
    input  wire logic       count_stop,
    input  wire logic       pin_level,
    input  wire logic [7:0] pre_latch,
    input  wire logic [7:0] tmr_latch,
    output var  logic       underflow,
    output var  logic       forced
);
    logic [3:0] div16;
    logic [7:0] pre;
    logic [7:0] tmr;
    logic       pin_d;
    logic       tick16;
    logic       fall;
    logic       pre_in;

    assign tick16 = (div16 == XPC_DIV16_LAST);
    assign fall   = pin_d && !pin_level;

    // Prescaler input: forced divide-by-16 after stop, else per mode
    always_comb begin
        pre_in = 1'b0;
        if (forced) begin
            pre_in = tick16;
        end else if (!count_stop) begin
            unique case (mode)
                XPC_TIMER_MODE:  pre_in = tick16;
                XPC_PULSE_OUT:   pre_in = tick16;
                XPC_EVENT_CNT:   pre_in = fall;
                XPC_PULSE_WIDTH: pre_in = tick16 && !pin_level;
            endcase
        end
    end

    // Oscillator divide-by-16 and pin edge history
    always_ff @(posedge clock) begin
        if (!rstn) begin
            div16 <= 4'h_0;
            pin_d <= 1'b1;
        end else if (ce && osc_run) begin
            div16 <= div16 + 4'h_1;
            pin_d <= pin_level;
        end
    end

    // Prescaler and timer count down, reload after zero
    always_ff @(posedge clock) begin
        if (!rstn) begin
            pre       <= XPC_PRE_X_STOP;
            tmr       <= XPC_TMR_X_STOP;
            underflow <= 1'b0;
        end else if (ce) begin
            underflow <= 1'b0;
            if (stop_load) begin
                pre <= XPC_PRE_X_STOP;
                tmr <= XPC_TMR_X_STOP;
            end else if (osc_run && pre_in) begin
                if (pre == 8'h_00) begin
                    pre <= pre_latch;
                    if (tmr == 8'h_00) begin
                        tmr       <= tmr_latch;
                        underflow <= 1'b1;
                    end else begin
                        tmr <= tmr - 8'h_01;
                    end
                end else begin
                    pre <= pre - 8'h_01;
                end
            end
        end
    end

    // Forced source set by stop, released by underflow or reset
    always_ff @(posedge clock) begin
        if (!rstn) begin
            forced <= 1'b0;
        end else if (ce) begin
            if (stop_load) begin
                forced <= 1'b1;
            end else if (underflow) begin
                forced <= 1'b0;
            end
        end
    end
endmodule : xpc_timer_x
`default_nettype wire

/* xpc_top.sv */
// Expander port, sync clock, interrupt pins and clock generator control
//
// Behaviour
// - While the sync clock is high the port carries the expander address, while low it carries data.
// - Port contents count only while select is low; the expander ignores the port while select is high.
// - Select goes low whenever the bus address lies in the expander range D0 to DF.
// - Read/write is low during an expander write and high during a read.
// - The sync clock runs at clock/4 and at clock/8 while select is active.
// - Reset output falls with reset input and rises 8 to 15 clocks after reset input rises.
// - A falling edge on the interrupt pin sets bit 1 of the interrupt control register.
// - A falling edge on the timer X pin sets bit 7 of the interrupt control register, except in pulse output mode.
// - The timer X pin counts events, toggles on underflow in pulse output mode, and gates pulse width mode.
// - The stop instruction halts the oscillator with the internal clock held high.
// - Stop loads prescaler X with FF, timer X with 01 and forces the divide-by-16 source.
// - The forced source is released on timer X underflow or reset.
// - After stop the oscillator restarts on interrupt acknowledge; the clock stays high until underflow.
// - Fast clock closes the oscillator switch, slow clock opens it, and reset closes it.
// - Software may clear the interrupt flags but never set them.
`default_nettype none
module xpc_top
    import xpc_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rstn,
    input  wire logic       ce,
    input  wire logic       reset_in_n,
    input  wire xpc_req_s   req,
    input  wire logic       req_valid,
    input  wire logic [3:0] port_in,
    input  wire logic       int_pin,
    input  wire logic       timer_x_pin_in,
    input  wire xpc_tmode_e tmode,
    input  wire logic       count_stop,
    input  wire logic [7:0] pre_latch,
    input  wire logic [7:0] tmr_latch,
    input  wire logic [7:0] icr_clear_mask,
    input  wire logic       icr_clear,
    input  wire logic       stop_instruction,
    input  wire logic       fast_clock_instruction,
    input  wire logic       slow_clock_instruction,
    input  wire logic       int_ack,
    output var  logic [3:0] port_out,
    output var  logic [3:0] port_oe,
    output var  logic [3:0] rdata,
    output var  logic       rdata_valid,
    output var  logic       select_n,
    output var  logic       rw,
    output var  logic       sync_clk,
    output var  logic       reset_out_n,
    output var  logic [7:0] icr,
    output var  logic       timer_x_pin_out,
    output var  logic       timer_x_pin_oe,
    output var  logic       osc_run,
    output var  logic       clk_gate_high,
    output var  logic       oscillator_feedback_switch
);
    logic       rst_sync_n;
    logic       int_level;
    logic       int_d;
    logic       tx_level;
    logic       tx_d;
    logic       underflow;
    logic       forced;
    logic       in_range;
    logic [2:0] half_cnt;
    logic [2:0] half_lim;
    logic       boundary;
    logic       next_sync;
    logic       next_select_n;
    logic       next_rw;
    logic [3:0] rst_cnt;
    logic       stop_load;

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    xpc_sync u_sync_rst (
        .clock (clock),
        .rstn  (rstn),
        .ce    (ce),
        .pin   (reset_in_n),
        .level (rst_sync_n)
    );

    xpc_sync u_sync_int (
        .clock (clock),
        .rstn  (rstn),
        .ce    (ce),
        .pin   (int_pin),
        .level (int_level)
    );

    xpc_sync u_sync_tx (
        .clock (clock),
        .rstn  (rstn),
        .ce    (ce),
        .pin   (timer_x_pin_in),
        .level (tx_level)
    );

    // ****************************************************************
    // Timer X
    // ****************************************************************
    assign stop_load = stop_instruction && osc_run;

    xpc_timer_x u_timer_x (
        .clock      (clock),
        .rstn       (rstn && rst_sync_n),
        .ce         (ce),
        .osc_run    (osc_run),
        .stop_load  (stop_load),
        .mode       (tmode),
        .count_stop (count_stop),
        .pin_level  (tx_level),
        .pre_latch  (pre_latch),
        .tmr_latch  (tmr_latch),
        .underflow  (underflow),
        .forced     (forced)
    );

    // ****************************************************************
    // Sync clock divider and expander port
    // ****************************************************************
    assign in_range = req_valid && (req.addr >= XPC_EXP_LO) && (req.addr <= XPC_EXP_HI);
    assign half_lim = select_n ? XPC_DIV_NORM_HALF : XPC_DIV_EXP_HALF;
    assign boundary = (half_cnt == half_lim) && !sync_clk; // End of a low phase
    assign next_sync = (half_cnt == half_lim) ? !sync_clk : sync_clk;

    // Half-period counter; ratio follows select, which moves only at boundaries or while the clock is held
    always_ff @(posedge clock) begin
        if (!rstn) begin
            half_cnt <= 3'h_0;
            sync_clk <= 1'b1;
        end else if (ce && osc_run && !clk_gate_high) begin
            sync_clk <= next_sync;
            half_cnt <= (half_cnt == half_lim) ? 3'h_0 : half_cnt + 3'h_1;
        end else if (ce) begin
            sync_clk <= 1'b1;
            half_cnt <= 3'h_0;
        end
    end

    // Select and direction change only at a full cycle boundary, or freely while the clock is held
    assign next_select_n = (boundary || clk_gate_high) ? !in_range : select_n;
    assign next_rw       = (boundary || clk_gate_high) ? !(in_range && req.write) : rw;

    // Registered select and direction; the port uses the same next values so both move on one edge
    always_ff @(posedge clock) begin
        if (!rstn) begin
            select_n <= 1'b1;
            rw       <= 1'b1;
        end else if (ce) begin
            select_n <= next_select_n;
            rw       <= next_rw;
        end
    end

    // Address in the high phase, write data or release in the low phase
    always_ff @(posedge clock) begin
        if (!rstn) begin
            port_out <= 4'h_0;
            port_oe  <= 4'h_0;
        end else if (ce) begin
            if (next_select_n) begin
                port_oe <= 4'h_0;
            end else if (next_sync) begin
                port_out <= req.addr[3:0];
                port_oe  <= 4'h_f;
            end else begin
                port_out <= req.wdata;
                port_oe  <= next_rw ? 4'h_0 : 4'h_f;
            end
        end
    end

    // Read data sampled at the end of the low phase
    always_ff @(posedge clock) begin
        if (!rstn) begin
            rdata       <= 4'h_0;
            rdata_valid <= 1'b0;
        end else if (ce) begin
            rdata_valid <= 1'b0;
            if (!select_n && rw && boundary) begin
                rdata       <= port_in;
                rdata_valid <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Reset output
    // ****************************************************************
    always_ff @(posedge clock) begin
        if (!rstn) begin
            rst_cnt     <= 4'h_0;
            reset_out_n <= 1'b0;
        end else if (ce) begin
            if (!rst_sync_n) begin
                rst_cnt     <= 4'h_0;
                reset_out_n <= 1'b0;
            end else if (rst_cnt != XPC_RST_DELAY) begin
                rst_cnt <= rst_cnt + 4'h_1;
            end else begin
                reset_out_n <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Interrupt request flags
    // ****************************************************************
    always_ff @(posedge clock) begin
        if (!rstn) begin
            int_d <= 1'b1;
            tx_d  <= 1'b1;
        end else if (ce) begin
            int_d <= int_level;
            tx_d  <= tx_level;
        end
    end

    // Clear first, then edges set; a set in the same cycle wins
    always_ff @(posedge clock) begin
        if (!rstn || !rst_sync_n) begin
            icr <= XPC_ICR_RESET;
        end else if (ce) begin
            for (int i = 0; i < 8; i++) begin
                if (icr_clear && icr_clear_mask[i]) begin
                    icr[i] <= 1'b0;
                end
            end
            if (int_d && !int_level) begin
                icr[XPC_INT_BIT] <= 1'b1;
            end
            if (tx_d && !tx_level && tmode != XPC_PULSE_OUT) begin
                icr[XPC_TMRX_PIN_BIT] <= 1'b1;
            end
        end
    end

    // Pulse output toggles on each underflow
    always_ff @(posedge clock) begin
        if (!rstn) begin
            timer_x_pin_out <= 1'b0;
            timer_x_pin_oe  <= 1'b0;
        end else if (ce) begin
            timer_x_pin_oe <= (tmode == XPC_PULSE_OUT);
            if (underflow && tmode == XPC_PULSE_OUT) begin
                timer_x_pin_out <= !timer_x_pin_out;
            end
        end
    end

    // ****************************************************************
    // Clock generator: stop, restart and oscillator switch
    // ****************************************************************
    always_ff @(posedge clock) begin
        if (!rstn || !rst_sync_n) begin
            osc_run       <= 1'b1;
            clk_gate_high <= 1'b0;
        end else if (ce) begin
            if (stop_load) begin
                osc_run       <= 1'b0;
                clk_gate_high <= 1'b1;
            end else if (!osc_run && int_ack) begin
                osc_run <= 1'b1;
            end else if (osc_run && forced && underflow) begin
                clk_gate_high <= 1'b0;
            end
        end
    end

    // Oscillator feedback switch
    always_ff @(posedge clock) begin
        if (!rstn || !rst_sync_n) begin
            oscillator_feedback_switch <= 1'b1;
        end else if (ce) begin
            if (fast_clock_instruction) begin
                oscillator_feedback_switch <= 1'b1;
            end else if (slow_clock_instruction) begin
                oscillator_feedback_switch <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    select_range_a : assert property (@(posedge clock) disable iff (!rstn)
        (ce && boundary && in_range) |=> !select_n) else $error("select did not follow range");
    direction_a : assert property (@(posedge clock) disable iff (!rstn)
        (!select_n && !rw && !sync_clk) |-> port_oe == 4'h_f) else $error("write data not driven");
    port_idle_a : assert property (@(posedge clock) disable iff (!rstn)
        select_n |-> port_oe == 4'h_0) else $error("port driven while idle");
    reset_low_a : assert property (@(posedge clock) disable iff (!rstn)
        (ce && !rst_sync_n) |=> !reset_out_n) else $error("reset output not low");
    flag_clear_a : assert property (@(posedge clock) disable iff (!rstn || !rst_sync_n)
        (ce && icr_clear && icr_clear_mask[XPC_INT_BIT] && !(int_d && !int_level)) |=> !icr[XPC_INT_BIT])
        else $error("flag not cleared");
    int_edge_a : assert property (@(posedge clock) disable iff (!rstn || !rst_sync_n)
        (ce && int_d && !int_level) |=> icr[XPC_INT_BIT]) else $error("int flag not set");
    stop_hold_a : assert property (@(posedge clock) disable iff (!rstn)
        clk_gate_high && $past(clk_gate_high) && $past(ce) |-> sync_clk) else $error("clock not held");
    fast_switch_a : assert property (@(posedge clock) disable iff (!rstn || !rst_sync_n)
        (ce && fast_clock_instruction) |=> oscillator_feedback_switch) else $error("switch not closed");
endmodule : xpc_top
`default_nettype wire

/* xpc_top_test.sv */
// Self-checking testbench for the expander port and clock control block
`default_nettype none
module xpc_top_test
    import xpc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic       clock, rstn, ce, reset_in_n, req_valid, int_pin, timer_x_pin_in, count_stop;
    logic       icr_clear, stop_instruction, fast_clock_instruction, slow_clock_instruction, int_ack;
    logic       rdata_valid, select_n, rw, sync_clk, reset_out_n, timer_x_pin_out, timer_x_pin_oe;
    logic       osc_run, clk_gate_high, oscillator_feedback_switch, v, bad;
    xpc_req_s   req;
    xpc_tmode_e tmode;
    logic [3:0] port_in, port_out, port_oe, rdata;
    logic [7:0] pre_latch, tmr_latch, icr_clear_mask, icr;
    int         n_errors, comparisons, cycles, k, n;
    logic [7:0] ta [4] = '{8'h_d0, 8'h_d5, 8'h_da, 8'h_df};
    logic [3:0] td [4] = '{4'h_3, 4'h_c, 4'h_5, 4'h_a};

    // ****************************************
    // Design, expander model and clock
    // ****************************************
    xpc_top xpc_top_i (
        .clock(clock), .rstn(rstn), .ce(ce), .reset_in_n(reset_in_n), .req(req), .req_valid(req_valid),
        .port_in(port_in), .int_pin(int_pin), .timer_x_pin_in(timer_x_pin_in), .tmode(tmode),
        .count_stop(count_stop), .pre_latch(pre_latch), .tmr_latch(tmr_latch),
        .icr_clear_mask(icr_clear_mask), .icr_clear(icr_clear), .stop_instruction(stop_instruction),
        .fast_clock_instruction(fast_clock_instruction), .slow_clock_instruction(slow_clock_instruction),
        .int_ack(int_ack), .port_out(port_out), .port_oe(port_oe), .rdata(rdata),
        .rdata_valid(rdata_valid), .select_n(select_n), .rw(rw), .sync_clk(sync_clk),
        .reset_out_n(reset_out_n), .icr(icr), .timer_x_pin_out(timer_x_pin_out),
        .timer_x_pin_oe(timer_x_pin_oe), .osc_run(osc_run), .clk_gate_high(clk_gate_high),
        .oscillator_feedback_switch(oscillator_feedback_switch)
    );

    xpc_exp_model xpc_exp_model_i (
        .clock(clock), .select_n(select_n), .sync_clk(sync_clk), .rw(rw), .port_out(port_out),
        .port_in(port_in)
    );

    // Free-running oscillator clock, 8 ns period
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // Hang guard: count cycles and give up well past the expected run
    always @(posedge clock) begin
        cycles++;
        if (cycles == 30000) begin
            n_errors++;
            conclude();
        end
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude

    // One-cycle pulse on a chosen instruction, clear or interrupt acknowledge strobe
    task automatic strobe(input int which);
        @(posedge clock);
        case (which)
            0: icr_clear <= 1'b1;
            1: stop_instruction <= 1'b1;
            2: fast_clock_instruction <= 1'b1;
            3: slow_clock_instruction <= 1'b1;
            default: int_ack <= 1'b1;
        endcase
        @(posedge clock);
        {icr_clear, stop_instruction, fast_clock_instruction, slow_clock_instruction, int_ack} <= '0;
        repeat (3) @(negedge clock);
    endtask : strobe

    // One expander access; for a read, d is the expected nibble
    task automatic access(input logic [7:0] a, input logic wr, input logic [3:0] d);
        int j;
        @(posedge clock);
        req <= '{addr: a, write: wr, wdata: d};
        req_valid <= 1'b1;
        j = 0;
        do begin @(negedge clock); j++; end while (select_n !== 1'b0 && j < 40);
        check(select_n, 1'b0);
        check(sync_clk, 1'b1);
        check(port_out, a[3:0]);
        check(port_oe, 4'h_f);
        check(rw, !wr);
        j = 0;
        do begin @(negedge clock); j++; end while (sync_clk !== 1'b0 && j < 8);
        check(select_n, 1'b0);
        check(port_oe, wr ? 4'h_f : 4'h_0);
        if (wr) check(port_out, d);
        repeat (2) @(posedge clock);
        req_valid <= 1'b0;
        j = 0;
        do begin @(negedge clock); j++; end while (select_n !== 1'b1 && j < 8);
        check(select_n, 1'b1);
        if (!wr) begin
            check(rdata_valid, 1'b1);
            check(rdata, d);
        end
    endtask : access

    // Clocks between two rising edges of the sync clock
    task automatic period(output int p);
        int j;
        j = 0;
        while (sync_clk !== 1'b0 && j < 20) begin @(negedge clock); j++; end
        while (sync_clk !== 1'b1 && j < 40) begin @(negedge clock); j++; end
        p = 0;
        while (sync_clk !== 1'b0 && p < 20) begin @(negedge clock); p++; end
        while (sync_clk !== 1'b1 && p < 20) begin @(negedge clock); p++; end
    endtask : period

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {rstn, reset_in_n, req_valid, icr_clear, stop_instruction} = '0;
        {fast_clock_instruction, slow_clock_instruction, int_ack} = '0;
        {ce, int_pin, timer_x_pin_in, count_stop, reset_in_n} = '1;
        req = '{addr: 8'h_00, write: 1'b0, wdata: 4'h_0};
        tmode = XPC_TIMER_MODE;
        {pre_latch, tmr_latch, icr_clear_mask} = {8'h_01, 8'h_01, 8'h_00};
        repeat (4) @(posedge clock);
        rstn <= 1'b1;
        repeat (2) @(negedge clock);
        check(select_n, 1'b1);
        check(icr, XPC_ICR_RESET);
        check(oscillator_feedback_switch, 1'b1);
        period(n);
        check(8'(n), 8'h_04);
        $display("Test reset and idle clock done");

        strobe(3);
        check(oscillator_feedback_switch, 1'b0);
        strobe(2);
        check(oscillator_feedback_switch, 1'b1);
        strobe(3);
        @(posedge clock);
        reset_in_n <= 1'b0;
        repeat (8) @(negedge clock);
        check(reset_out_n, 1'b0);
        check(oscillator_feedback_switch, 1'b1);
        @(posedge clock);
        reset_in_n <= 1'b1;
        k = 0;
        do begin @(negedge clock); k++; end while (reset_out_n !== 1'b1 && k < 30);
        check((k - 1 >= 8) && (k - 1 <= 15), 1'b1);
        $display("Test reset output and oscillator switch done");

        for (int i = 0; i < 4; i++) access(ta[i], 1'b1, td[i]);
        for (int i = 0; i < 4; i++) access(ta[i], 1'b0, td[i]);
        bad = 1'b0;
        foreach (ta[i]) begin
            @(posedge clock);
            req <= '{addr: ta[i] ^ 8'h_30, write: i[0], wdata: 4'h_9};
            req_valid <= 1'b1;
            repeat (16) @(negedge clock) if (select_n !== 1'b1 || port_oe !== 4'h_0) bad = 1'b1;
        end
        check(bad, 1'b0);
        @(posedge clock);
        req <= '{addr: 8'h_d5, write: 1'b0, wdata: 4'h_0};
        repeat (12) @(negedge clock);
        period(n);
        check(8'(n), 8'h_08);
        @(posedge clock);
        req_valid <= 1'b0;
        repeat (20) @(negedge clock);
        check(select_n, 1'b1);
        $display("Test expander port done");

        @(posedge clock);
        int_pin <= 1'b0;
        repeat (10) @(negedge clock);
        check(icr[XPC_INT_BIT], 1'b1);
        @(posedge clock);
        timer_x_pin_in <= 1'b0;
        repeat (10) @(negedge clock);
        check(icr[XPC_TMRX_PIN_BIT], 1'b1);
        @(posedge clock);
        icr_clear_mask <= 8'h_02;
        strobe(0);
        check(icr[XPC_INT_BIT], 1'b0);
        check(icr[XPC_TMRX_PIN_BIT], 1'b1);
        @(posedge clock);
        icr_clear_mask <= 8'h_ff;
        strobe(0);
        check({icr[XPC_TMRX_PIN_BIT], icr[XPC_INT_BIT]}, 2'b00);
        $display("Test interrupt pins done");

        @(posedge clock);
        tmode <= XPC_PULSE_OUT;
        count_stop <= 1'b0;
        repeat (4) @(negedge clock);
        check(timer_x_pin_oe, 1'b1);
        v = timer_x_pin_out;
        k = 0;
        do begin @(negedge clock); k++; end while (timer_x_pin_out === v && k < 15000);
        check(timer_x_pin_out, !v);
        k = 0;
        do begin @(negedge clock); k++; end while (timer_x_pin_out !== v && k < 400);
        check(timer_x_pin_out, v);
        $display("Test pulse output done");

        @(posedge clock);
        tmode <= XPC_TIMER_MODE;
        strobe(1);
        check({osc_run, clk_gate_high}, 2'b01);
        repeat (50) @(negedge clock);
        check({osc_run, clk_gate_high}, 2'b01);
        strobe(4);
        check({osc_run, clk_gate_high}, 2'b11);
        k = 0;
        do begin @(negedge clock); k++; end while (clk_gate_high !== 1'b0 && k < 20000);
        check(clk_gate_high, 1'b0);
        check(k > 4000, 1'b1);
        $display("Test stop and restart done");
        conclude();
    end
endmodule : xpc_top_test
`default_nettype wire
